/* inc/secu_regs.svh */
// Register offsets, field positions, reset values and timing counts
// of the status, event and control unit.
// Assumes a 32-bit APB with 12 address bits and a 50 MHz pclk.
`ifndef SECU_REGS_SVH
`define SECU_REGS_SVH

// ==========================================================
// Timing
`define SECU_CLK_HZ        50000000
`define SECU_MS_PER_S      1000
`define SECU_DEB_MS        20
`define SECU_PULSE_MIN_MS  100
`define SECU_PULSE_MAX_MS  2000
`define SECU_SYNC_MIN_MIN  5
`define SECU_SYNC_MAX_MIN  60
`define SECU_MS_PER_MIN    60000

// ==========================================================
// Byte offsets
`define SECU_OFF_TIME      12'h000
`define SECU_OFF_SYNC_IVL  12'h004
`define SECU_OFF_PT_STATE  12'h008
`define SECU_OFF_DP_CFG    12'h00C
`define SECU_OFF_DP_STATE  12'h010
`define SECU_OFF_EVT_EN    12'h014
`define SECU_OFF_CHAT_CFG  12'h018
`define SECU_OFF_CFG_IDX   12'h01C
`define SECU_OFF_CTL_CFG   12'h020
`define SECU_OFF_CTL_CMD   12'h024
`define SECU_OFF_CTL_STAT  12'h028
`define SECU_OFF_EVT_CNT   12'h02C
`define SECU_OFF_EVT_TIME  12'h030
`define SECU_OFF_EVT_INFO  12'h034
`define SECU_OFF_EVT_POP   12'h038
`define SECU_OFF_DIAG      12'h03C

// ==========================================================
// Field positions
`define SECU_CMD_EXEC_BIT  8
`define SECU_DG_CHAT       0
`define SECU_DG_REFUSE     1
`define SECU_DG_SEL_TO     2
`define SECU_DG_OVFL       3
`define SECU_DG_SYNC_LOST  4
`define SECU_DG_MEM        5
`define SECU_DG_CPU        6
`define SECU_DG_IO         7
`define SECU_DG_LOCAL      8

// ==========================================================
// Reset values
`define SECU_RST_SYNC_IVL  8'h05
`define SECU_RST_CHAT_WIN  16'h03E8
`define SECU_RST_CHAT_MAX  8'h00
`define SECU_RST_PULSE     16'h01F4
`define SECU_RST_SEL_TO    16'h2710

`endif

/* inc/secu_pkg.sv */
// Types shared by the status, event and control unit.
// Assumes secu_regs.svh supplies the numeric constants.
package secu_pkg;

  // ==========================================================
  // Control sequence states, one-hot
  typedef enum logic [2:0] {
    CTL_IDLE     = 3'b001,
    CTL_SELECTED = 3'b010,
    CTL_EXECUTE  = 3'b100
  } secu_ctl_state_type;

  // ==========================================================
  // APB request as seen by the slave
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } secu_apb_req_type;

  // ==========================================================
  // One time-tagged event record
  typedef struct packed {
    logic [31:0] stamp;
    logic [7:0]  point;
    logic        value;
  } secu_evt_rec_type;

endpackage

/* core/secu_top.sv */
// Status scan, debounce, chatter filter, event log and select-execute control.
// Assumes synchronous field inputs, an APB master and a retained log domain
// that is reset only by backup_rstn.
//
// Summary of operation
// RULE_01 - Accept change only after 20 ms stable
// RULE_02 - Separate debounce state per input
// RULE_03 - Reject changes exceeding count within window
// RULE_04 - Single point reported as one bit
// RULE_05 - Double point two bits, valid one-closed
// RULE_06 - Both open or both closed: invalid
// RULE_07 - Sample every input once per millisecond
// RULE_08 - Timestamps at 10 ms or finer
// RULE_09 - Time of day loaded by master
// RULE_10 - Event logging enabled per point
// RULE_11 - Changed logging point writes stamped record
// RULE_12 - Log holds at least 300 records
// RULE_13 - Log survives supply interruption
// RULE_14 - Select then execute; pulse 0.1-2 s
// RULE_15 - Only one point selected or executing
// RULE_16 - Selection cancelled after timeout
// RULE_17 - No output during power up/down
// RULE_18 - Local/remote switch reported as status
// RULE_19 - Master syncs every 5 to 60 min
// RULE_20 - Report memory, processor, port faults
// RULE_21 - Digital changes before analog reports
// RULE_22 - Double point 01 open, 10 closed
// RULE_23 - Per-point filter and control settings writable
`timescale 1ns/1ps
`include "secu_regs.svh"

module secu_top #(
  parameter int NUM_IN     = 16,
  parameter int NUM_CTL    = 4,
  parameter int LOG_DEPTH  = 512,
  parameter int CYC_PER_MS = `SECU_CLK_HZ / `SECU_MS_PER_S
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     backup_rstn,
  input  wire secu_pkg::secu_apb_req_type apb_req,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic [NUM_IN-1:0]        field_in,
  input  wire logic                     local_remote,
  input  wire logic                     power_good,
  input  wire logic                     fault_mem,
  input  wire logic                     fault_cpu,
  input  wire logic                     fault_io,
  input  wire logic                     analog_req,
  output logic                          analog_grant,
  output logic [NUM_CTL-1:0]            ctl_out,
  output logic                          diag_alarm
);
  import secu_pkg::*;

  localparam int IW = $clog2(NUM_IN);
  localparam int CW = $clog2(NUM_CTL);
  localparam int PW = $clog2(LOG_DEPTH);
  localparam int NP = NUM_IN / 2;

  // ==========================================================
  // Elaboration checks
  initial begin
    if (NUM_IN < 2 || NUM_IN > 16 || (NUM_IN % 2) != 0)
      $error("NUM_IN must be even, 2 to 16");
    if (NUM_CTL < 2 || NUM_CTL > 8)
      $error("NUM_CTL must be 2 to 8");
    if (LOG_DEPTH < 300 || LOG_DEPTH > 65535)
      $error("LOG_DEPTH must be 300 to 65535");
    if (CYC_PER_MS < 2 || CYC_PER_MS > 65535)
      $error("CYC_PER_MS out of range");
  end

  // ==========================================================
  // Functions
  // Legal register address
  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a[1:0] == 2'b00) && (a <= `SECU_OFF_DIAG);
  endfunction

  // Lowest set bit of a pending vector
  function automatic logic [IW-1:0] first_set(input logic [NUM_IN-1:0] v);
    first_set = '0;
    for (int i = NUM_IN - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = IW'(i);
      end
    end
  endfunction

  // Pulse width held inside its legal span
  function automatic logic [15:0] clamp_pulse(input logic [15:0] w);
    if (w < 16'(`SECU_PULSE_MIN_MS)) begin
      clamp_pulse = 16'(`SECU_PULSE_MIN_MS);
    end else if (w > 16'(`SECU_PULSE_MAX_MS)) begin
      clamp_pulse = 16'(`SECU_PULSE_MAX_MS);
    end else begin
      clamp_pulse = w;
    end
  endfunction

  // ==========================================================
  // Declarations
  logic [15:0]        ms_div_reg;
  logic               ms_tick_reg;
  logic [31:0]        tod_reg;
  logic [31:0]        scan_stamp_reg;
  logic [31:0]        sync_age_reg;
  logic [7:0]         sync_ivl_reg;
  logic               local_reg;
  logic [NUM_IN-1:0]  stable_reg;
  logic [NUM_IN-1:0]  pend_reg;
  logic [NUM_IN-1:0]  chat_rej_reg;
  logic [4:0]         deb_cnt_reg [NUM_IN];
  logic [15:0]        win_tmr_reg [NUM_IN];
  logic [7:0]         ops_cnt_reg [NUM_IN];
  logic [15:0]        chat_win_reg [NUM_IN];
  logic [7:0]         chat_max_reg [NUM_IN];
  logic [NP-1:0]      dp_cfg_reg;
  logic [NUM_IN-1:0]  evt_en_reg;
  logic [7:0]         cfg_idx_reg;
  logic [15:0]        pulse_reg [NUM_CTL];
  logic [15:0]        sel_to_reg [NUM_CTL];
  secu_ctl_state_type ctl_state_reg;
  logic [CW-1:0]      sel_pt_reg;
  logic [15:0]        ctl_tmr_reg;
  logic               refuse_reg;
  logic               sel_to_reg_evt;
  logic               fsm_bad_reg;
  secu_evt_rec_type   log_mem [LOG_DEPTH];
  logic [PW-1:0]      wr_ptr_reg;
  logic [PW-1:0]      rd_ptr_reg;
  logic [15:0]        log_cnt_reg;
  logic               ovfl_reg;
  logic [8:0]         diag_reg;
  logic [8:0]         diag_set;
  logic [31:0]        rd_next;
  logic [15:0]        dp_code;
  logic [7:0]         dp_bad;
  logic [IW-1:0]      pick_idx;
  logic               pick_vld;
  logic               log_push;
  logic               log_pop;
  logic               acc;
  logic               wr_en;
  logic               cmd_wr;
  logic               cmd_exec;
  logic [7:0]         cmd_pt;
  logic               cfg_in_ok;
  logic               cfg_ctl_ok;
  secu_evt_rec_type   head_rec;

  // ==========================================================
  // APB slave: answer one cycle into the access phase
  assign acc    = apb_req.psel & apb_req.penable & ~pready;
  assign wr_en  = apb_req.psel & apb_req.penable & pready & apb_req.pwrite & ~pslverr;
  assign cmd_wr = wr_en && (apb_req.paddr == `SECU_OFF_CTL_CMD);
  assign cmd_exec = apb_req.pwdata[`SECU_CMD_EXEC_BIT];
  assign cmd_pt   = apb_req.pwdata[7:0];
  assign cfg_in_ok  = (cfg_idx_reg < 8'(NUM_IN));
  assign cfg_ctl_ok = (cfg_idx_reg < 8'(NUM_CTL));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= acc;
      pslverr <= acc & ~addr_ok(apb_req.paddr);
      prdata  <= (acc && !apb_req.pwrite) ? rd_next : 32'h0000_0000;
    end
  end

  // Double point codes: even input is the NO contact, odd the NC contact
  always_comb begin
    dp_code = 16'h0000;
    dp_bad  = 8'h00;
    for (int k = 0; k < NP; k++) begin
      dp_code[2*k +: 2] = {stable_reg[2*k], stable_reg[2*k+1]}; // see RULE_05 RULE_22
      dp_bad[k] = dp_cfg_reg[k] & (stable_reg[2*k] == stable_reg[2*k+1]); // see RULE_06
    end
  end

  assign head_rec = log_mem[rd_ptr_reg];

  // Read data multiplexer
  always_comb begin
    rd_next = 32'h0000_0000;
    case (apb_req.paddr)
      `SECU_OFF_TIME:     rd_next = tod_reg;
      `SECU_OFF_SYNC_IVL: rd_next = {24'h00_0000, sync_ivl_reg};
      `SECU_OFF_PT_STATE: rd_next = 32'(stable_reg); // see RULE_04
      `SECU_OFF_DP_CFG:   rd_next = 32'(dp_cfg_reg);
      `SECU_OFF_DP_STATE: rd_next = {8'h00, dp_bad, dp_code};
      `SECU_OFF_EVT_EN:   rd_next = 32'(evt_en_reg);
      `SECU_OFF_CHAT_CFG: rd_next = cfg_in_ok ?
        {8'h00, chat_max_reg[cfg_idx_reg[IW-1:0]], chat_win_reg[cfg_idx_reg[IW-1:0]]} :
        32'h0000_0000;
      `SECU_OFF_CFG_IDX:  rd_next = {24'h00_0000, cfg_idx_reg};
      `SECU_OFF_CTL_CFG:  rd_next = cfg_ctl_ok ?
        {sel_to_reg[cfg_idx_reg[CW-1:0]], pulse_reg[cfg_idx_reg[CW-1:0]]} : 32'h0000_0000;
      `SECU_OFF_CTL_STAT: rd_next = {20'h0_0000, ctl_out == '0 ? 1'b0 : 1'b1,
                                     ctl_state_reg, 8'(sel_pt_reg)};
      `SECU_OFF_EVT_CNT:  rd_next = {15'h0000, ovfl_reg, log_cnt_reg};
      `SECU_OFF_EVT_TIME: rd_next = (log_cnt_reg != 16'h0000) ? head_rec.stamp : 32'h0000_0000;
      `SECU_OFF_EVT_INFO: rd_next = (log_cnt_reg != 16'h0000) ?
        {15'h0000, 1'b1, 7'h00, head_rec.value, head_rec.point} : 32'h0000_0000;
      `SECU_OFF_DIAG:     rd_next = {23'h00_0000, diag_reg};
      default:            rd_next = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // Time base, time of day and sync watch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_div_reg  <= 16'h0000;
      ms_tick_reg <= 1'b0;
    end else begin
      ms_tick_reg <= (ms_div_reg == 16'(CYC_PER_MS - 1));
      ms_div_reg  <= (ms_div_reg == 16'(CYC_PER_MS - 1)) ? 16'h0000 : ms_div_reg + 16'h0001;
    end
  end

  // Time of day counts milliseconds; a master sync message loads it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tod_reg        <= 32'h0000_0000;
      scan_stamp_reg <= 32'h0000_0000;
      sync_age_reg   <= 32'h0000_0000;
      sync_ivl_reg   <= `SECU_RST_SYNC_IVL;
    end else begin
      if (wr_en && apb_req.paddr == `SECU_OFF_TIME) begin
        tod_reg      <= apb_req.pwdata; // see RULE_09
        sync_age_reg <= 32'h0000_0000;
      end else if (ms_tick_reg) begin
        tod_reg      <= tod_reg + 32'h0000_0001; // see RULE_08
        sync_age_reg <= (sync_age_reg == 32'hFFFF_FFFF) ? sync_age_reg :
                        sync_age_reg + 32'h0000_0001;
      end
      if (ms_tick_reg) begin
        scan_stamp_reg <= tod_reg;
      end
      if (wr_en && apb_req.paddr == `SECU_OFF_SYNC_IVL) begin
        if (apb_req.pwdata[7:0] < 8'(`SECU_SYNC_MIN_MIN)) begin
          sync_ivl_reg <= 8'(`SECU_SYNC_MIN_MIN); // see RULE_19
        end else if (apb_req.pwdata[7:0] > 8'(`SECU_SYNC_MAX_MIN)) begin
          sync_ivl_reg <= 8'(`SECU_SYNC_MAX_MIN);
        end else begin
          sync_ivl_reg <= apb_req.pwdata[7:0];
        end
      end
    end
  end

  // ==========================================================
  // Configuration storage written by the master
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dp_cfg_reg  <= '0;
      evt_en_reg  <= '0;
      cfg_idx_reg <= 8'h00;
      for (int i = 0; i < NUM_IN; i++) begin
        chat_win_reg[i] <= `SECU_RST_CHAT_WIN;
        chat_max_reg[i] <= `SECU_RST_CHAT_MAX;
      end
      for (int j = 0; j < NUM_CTL; j++) begin
        pulse_reg[j]  <= `SECU_RST_PULSE;
        sel_to_reg[j] <= `SECU_RST_SEL_TO;
      end
    end else if (wr_en) begin
      case (apb_req.paddr)
        `SECU_OFF_DP_CFG:  dp_cfg_reg  <= apb_req.pwdata[NP-1:0];
        `SECU_OFF_EVT_EN:  evt_en_reg  <= apb_req.pwdata[NUM_IN-1:0]; // see RULE_10
        `SECU_OFF_CFG_IDX: cfg_idx_reg <= apb_req.pwdata[7:0];
        `SECU_OFF_CHAT_CFG: begin
          if (cfg_in_ok) begin
            chat_win_reg[cfg_idx_reg[IW-1:0]] <= apb_req.pwdata[15:0]; // see RULE_23
            chat_max_reg[cfg_idx_reg[IW-1:0]] <= apb_req.pwdata[23:16];
          end
        end
        `SECU_OFF_CTL_CFG: begin
          if (cfg_ctl_ok) begin
            pulse_reg[cfg_idx_reg[CW-1:0]]  <= clamp_pulse(apb_req.pwdata[15:0]); // see RULE_14
            sel_to_reg[cfg_idx_reg[CW-1:0]] <= (apb_req.pwdata[31:16] == 16'h0000) ?
                                               16'h0001 : apb_req.pwdata[31:16];
          end
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Per-input scan, debounce and chatter filter
  assign pick_vld = |pend_reg;
  assign pick_idx = first_set(pend_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable_reg   <= '0;
      pend_reg     <= '0;
      chat_rej_reg <= '0;
      local_reg    <= 1'b0;
      for (int i = 0; i < NUM_IN; i++) begin
        deb_cnt_reg[i] <= 5'h00;
        win_tmr_reg[i] <= 16'h0000;
        ops_cnt_reg[i] <= 8'h00;
      end
    end else begin
      chat_rej_reg <= '0;
      if (ms_tick_reg) begin
        local_reg <= local_remote; // see RULE_18
      end
      for (int i = 0; i < NUM_IN; i++) begin
        // Log writer takes one pending change per cycle
        if (pick_vld && pick_idx == IW'(i)) begin
          pend_reg[i] <= 1'b0;
        end
        if (ms_tick_reg) begin // see RULE_07
          if (win_tmr_reg[i] >= chat_win_reg[i]) begin
            win_tmr_reg[i] <= 16'h0000;
            ops_cnt_reg[i] <= 8'h00;
          end else begin
            win_tmr_reg[i] <= win_tmr_reg[i] + 16'h0001;
          end
          if (field_in[i] == stable_reg[i]) begin
            deb_cnt_reg[i] <= 5'h00; // see RULE_02
          end else if (deb_cnt_reg[i] < 5'(`SECU_DEB_MS - 1)) begin
            deb_cnt_reg[i] <= deb_cnt_reg[i] + 5'h01; // see RULE_01
          end else begin
            deb_cnt_reg[i] <= 5'h00;
            if (chat_max_reg[i] != 8'h00 && ops_cnt_reg[i] >= chat_max_reg[i] &&
                win_tmr_reg[i] < chat_win_reg[i]) begin
              chat_rej_reg[i] <= 1'b1; // see RULE_03
            end else begin
              stable_reg[i]  <= field_in[i];
              ops_cnt_reg[i] <= (win_tmr_reg[i] >= chat_win_reg[i]) ? 8'h01 :
                                (ops_cnt_reg[i] == 8'hFF) ? 8'hFF : ops_cnt_reg[i] + 8'h01;
              if (evt_en_reg[i]) begin
                pend_reg[i] <= 1'b1; // see RULE_11
              end
            end
          end
        end
      end
    end
  end

  // ==========================================================
  // Event log: pointers live in the retained domain
  assign log_push = pick_vld && (log_cnt_reg < 16'(LOG_DEPTH)); // see RULE_12
  assign log_pop  = wr_en && (apb_req.paddr == `SECU_OFF_EVT_POP) && (log_cnt_reg != 16'h0000);

  always_ff @(posedge pclk or negedge backup_rstn) begin
    if (!backup_rstn) begin
      wr_ptr_reg  <= '0; // see RULE_13
      rd_ptr_reg  <= '0;
      log_cnt_reg <= 16'h0000;
      ovfl_reg    <= 1'b0;
    end else begin
      if (log_push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(LOG_DEPTH - 1)) ? '0 : wr_ptr_reg + PW'(1);
      end
      if (log_pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(LOG_DEPTH - 1)) ? '0 : rd_ptr_reg + PW'(1);
      end
      log_cnt_reg <= log_cnt_reg + (log_push ? 16'h0001 : 16'h0000)
                                 - (log_pop ? 16'h0001 : 16'h0000);
      ovfl_reg    <= pick_vld & ~log_push;
    end
  end

  // Record storage, never cleared so records outlast a reset
  always_ff @(posedge pclk) begin
    if (log_push) begin
      log_mem[wr_ptr_reg] <= '{stamp: scan_stamp_reg, point: 8'(pick_idx),
                               value: stable_reg[pick_idx]}; // see RULE_11
    end
  end

  // Analog reports only once no digital change waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_grant <= 1'b0;
    end else begin
      analog_grant <= analog_req && log_cnt_reg == 16'h0000 && !pick_vld; // see RULE_21
    end
  end

  // ==========================================================
  // Select, check and execute sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_state_reg  <= CTL_IDLE;
      sel_pt_reg     <= '0;
      ctl_tmr_reg    <= 16'h0000;
      refuse_reg     <= 1'b0;
      sel_to_reg_evt <= 1'b0;
      fsm_bad_reg    <= 1'b0;
    end else begin
      refuse_reg     <= 1'b0;
      sel_to_reg_evt <= 1'b0;
      fsm_bad_reg    <= 1'b0;
      unique case (ctl_state_reg)
        CTL_IDLE: begin
          if (cmd_wr && !cmd_exec && power_good && cmd_pt < 8'(NUM_CTL)) begin
            ctl_state_reg <= CTL_SELECTED; // see RULE_14
            sel_pt_reg    <= cmd_pt[CW-1:0];
            ctl_tmr_reg   <= 16'h0000;
          end else if (cmd_wr) begin
            refuse_reg <= 1'b1;
          end
        end
        CTL_SELECTED: begin
          if (!power_good) begin
            ctl_state_reg <= CTL_IDLE; // see RULE_17
          end else if (cmd_wr && cmd_exec && cmd_pt == 8'(sel_pt_reg)) begin
            ctl_state_reg <= CTL_EXECUTE;
            ctl_tmr_reg   <= 16'h0000;
          end else if (cmd_wr) begin
            refuse_reg <= 1'b1; // see RULE_15
          end else if (ms_tick_reg) begin
            if (ctl_tmr_reg + 16'h0001 >= sel_to_reg[sel_pt_reg]) begin
              ctl_state_reg  <= CTL_IDLE; // see RULE_16
              sel_to_reg_evt <= 1'b1;
            end else begin
              ctl_tmr_reg <= ctl_tmr_reg + 16'h0001;
            end
          end
        end
        CTL_EXECUTE: begin
          if (cmd_wr) begin
            refuse_reg <= 1'b1; // see RULE_15
          end
          if (!power_good) begin
            ctl_state_reg <= CTL_IDLE; // see RULE_17
          end else if (ms_tick_reg) begin
            if (ctl_tmr_reg + 16'h0001 >= pulse_reg[sel_pt_reg]) begin
              ctl_state_reg <= CTL_IDLE; // see RULE_14
            end else begin
              ctl_tmr_reg <= ctl_tmr_reg + 16'h0001;
            end
          end
        end
        default: begin
          ctl_state_reg <= CTL_IDLE;
          fsm_bad_reg   <= 1'b1;
        end
      endcase
    end
  end

  // Output relay drive, cleared on the clock edge after power_good falls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_out <= '0;
    end else begin
      ctl_out <= (ctl_state_reg == CTL_EXECUTE && power_good) ?
                 NUM_CTL'(1) << sel_pt_reg : '0; // see RULE_17
    end
  end

  // ==========================================================
  // Diagnostics: bits 7:0 sticky, write one to clear, a new event wins; bit 8 follows local_reg
  always_comb begin
    diag_set = 9'h000;
    diag_set[`SECU_DG_CHAT]      = |chat_rej_reg;
    diag_set[`SECU_DG_REFUSE]    = refuse_reg;
    diag_set[`SECU_DG_SEL_TO]    = sel_to_reg_evt;
    diag_set[`SECU_DG_OVFL]      = ovfl_reg;
    diag_set[`SECU_DG_SYNC_LOST] = sync_age_reg >=
                                   32'(sync_ivl_reg) * 32'(`SECU_MS_PER_MIN);
    diag_set[`SECU_DG_MEM]       = fault_mem; // see RULE_20
    diag_set[`SECU_DG_CPU]       = fault_cpu;
    diag_set[`SECU_DG_IO]        = fault_io | fsm_bad_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diag_reg   <= 9'h000;
      diag_alarm <= 1'b0;
    end else begin
      if (wr_en && apb_req.paddr == `SECU_OFF_DIAG) begin
        diag_reg[7:0] <= (diag_reg[7:0] & ~apb_req.pwdata[7:0]) | diag_set[7:0];
      end else begin
        diag_reg[7:0] <= diag_reg[7:0] | diag_set[7:0];
      end
      diag_reg[`SECU_DG_LOCAL] <= local_reg; // see RULE_18
      diag_alarm <= |diag_reg[7:5]; // see RULE_20
    end
  end

endmodule

/* bench/secu_asserts.sv */
// Port checks for the unit.
// Assumes one pclk domain reset by presetn.
`timescale 1ns/1ps
module secu_asserts #(
  parameter int NUM_CTL = 4
) (
  input logic                       pclk,
  input logic                       presetn,
  input secu_pkg::secu_apb_req_type apb_req,
  input logic [31:0]                prdata,
  input logic                       pready,
  input logic                       pslverr,
  input logic                       power_good,
  input logic                       fault_mem,
  input logic                       analog_req,
  input logic                       analog_grant,
  input logic [NUM_CTL-1:0]         ctl_out,
  input logic                       diag_alarm
);
  import secu_pkg::*;
  // =====
  // Properties
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence access_s;
    apb_req.psel && apb_req.penable && !pready;
  endsequence
  apb_ready_a: assert property (access_s |=> pready)
    else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held");
  slverr_addr_a: assert property (pready && apb_req.paddr > 12'h03C |-> pslverr)
    else $error("no slverr");
  rdata_idle_a: assert property (!pready |-> prdata == '0)
    else $error("prdata not zero");
  ctl_onehot_a: assert property ($onehot0(ctl_out))
    else $error("two outputs on");
  ctl_power_a: assert property (!power_good |=> ctl_out == '0)
    else $error("output without power");
  fault_alarm_a: assert property (fault_mem |-> ##2 diag_alarm)
    else $error("no alarm");
  grant_req_a: assert property (analog_grant |-> $past(analog_req))
    else $error("grant unasked");
endmodule
bind secu_top secu_asserts #(.NUM_CTL(NUM_CTL)) secu_asserts_inst (.pclk, .presetn, .apb_req,
  .prdata, .pready, .pslverr, .power_good, .fault_mem, .analog_req, .analog_grant, .ctl_out,
  .diag_alarm);

/* bench/secu_master.sv */
// APB master standing in for the master station.
// Assumes the bench watchdog ends any hang.
`timescale 1ns/1ps
module secu_master (
  input  logic                       pclk,
  output secu_pkg::secu_apb_req_type apb_req,
  input  logic [31:0]                prdata,
  input  logic                       pready,
  input  logic                       pslverr
);
  import secu_pkg::*;
  // =====
  // One transfer, held until pready
  initial apb_req = '0;
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    apb_req <= '0;
  endtask
endmodule

/* bench/secu_top_bench.sv */
// Self-checking bench for the unit.
// Assumes secu_master drives APB; one ms is 50 cycles.
`timescale 1ns/1ps
module secu_top_bench;
  import secu_pkg::*;
  localparam int MS = 50;
  logic pclk = 0, presetn = 0, backup_rstn = 0, power_good = 0, fault_mem = 0, analog_req = 0;
  logic [15:0] field_in = '0;
  logic [3:0] ctl_out;
  logic [31:0] prdata, q;
  logic pready, pslverr, analog_grant, diag_alarm, e, local_remote = 0;
  secu_apb_req_type apb_req;
  int err_count = 0, check_count = 0, n;
  // =====
  // Clock and instances
  always #10 pclk = ~pclk;
  secu_top #(.CYC_PER_MS(MS)) secu_top_inst (.pclk, .presetn, .backup_rstn, .apb_req, .prdata,
    .pready, .pslverr, .field_in, .local_remote, .power_good, .fault_mem, .fault_cpu(1'b0),
    .fault_io(1'b0), .analog_req, .analog_grant, .ctl_out, .diag_alarm);
  secu_master secu_master_inst (.pclk, .apb_req, .prdata, .pready, .pslverr);
  task automatic chk(string s, logic [31:0] x, logic [31:0] y);
    check_count++;
    if (y !== x) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", s, x, y);
    end
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    secu_master_inst.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(logic [11:0] a);
    secu_master_inst.xfer(1'b0, a, '0, q, e);
  endtask
  task automatic wt(int m);
    repeat (m * MS) @(posedge pclk);
  endtask
  task automatic t_dp;
    wr(12'h00C, 1);
    wr(12'h014, 1);
    wr(12'h004, 70);
    rd(12'h004);
    chk("sync", 60, q);
    wr(12'h01C, 2);
    wr(12'h018, 32'h0001_03E8);
    field_in[2] <= 1'b1;
    wt(22);
    field_in[2] <= 1'b0;
    wt(22);
    rd(12'h03C);
    chk("chatter", 1, q[0]);
    wr(12'h000, 1000);
    field_in[0] <= 1'b1;
    wt(19);
    field_in[0] <= 1'b0;
    wt(3);
    rd(12'h008);
    chk("bounce", 4, q);
    for (int i = 1; i < 4; i++) begin
      field_in[1:0] <= 2'(i);
      wt(22);
      rd(12'h010);
      chk("dpoint", {i[0] == i[1], i[0], i[1]}, {q[16], q[1:0]});
    end
    chk("grant", 0, analog_grant);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h02C);
    chk("count", 3, q[15:0]);
    rd(12'h030);
    chk("stamp", 1, q >= 1038 && q <= 1046);
    repeat (3) wr(12'h038, 0);
    repeat (2) @(posedge pclk);
    chk("grant", 1, analog_grant);
    rd(12'h040);
    chk("slverr", 1, e);
    $display("t_dp done");
  endtask
  task automatic t_ctl;
    local_remote <= 1'b1;
    wr(12'h020, 32'h0005_0064);
    wr(12'h024, 0);
    wt(8);
    rd(12'h028);
    chk("timeout", 3'b001, q[10:8]);
    wr(12'h024, 0);
    wr(12'h024, 1);
    wr(12'h024, 32'h0000_0100);
    n = 0;
    while (ctl_out !== 4'h1 && n < 9) begin
      @(posedge pclk);
      n++;
    end
    n = 0;
    while (ctl_out === 4'h1) begin
      @(posedge pclk);
      n++;
    end
    chk("pulse", 1, n >= 4940 && n <= 5060);
    rd(12'h03C);
    chk("diag", 3'b110, q[2:0]);
    chk("local", 1, q[8]);
    wr(12'h024, 0);
    wr(12'h024, 32'h0000_0100);
    wt(10);
    power_good <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("power", 0, ctl_out);
    power_good <= 1'b1;
    fault_mem <= 1'b1;
    @(posedge pclk);
    fault_mem <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("alarm", 1, diag_alarm);
    $display("t_ctl done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Main sequence and watchdog
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    backup_rstn <= 1'b1;
    power_good <= 1'b1;
    analog_req <= 1'b1;
    t_dp;
    t_ctl;
    summarize;
  end
  initial begin
    repeat (30000) @(posedge pclk);
    err_count++;
    summarize;
  end
endmodule
